/* hw/obm_top.sv */
// output mapping broker with id source selection and axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
module obm_top
  import obm_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC,
  parameter int PROC_CYCLES = PROC_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq,
  // producer writes into the input data area
  input wire logic prod_we,
  input wire logic [15:0] prod_addr,
  input wire logic [15:0] prod_data,
  // consumer output data
  input wire logic [1:0] cons_sel,
  input wire logic [3:0] cons_idx,
  output logic [15:0] cons_data,
  output logic [2:0] cons_stale,
  // identifiers
  input wire logic [15:0] sw_pins,
  input wire logic [15:0] master_alias,
  output logic [15:0] station_alias,
  output logic [15:0] device_id
);

  // ******************************************************************
  // state
  // ******************************************************************
  logic rst_ff_q, rst_sync_n_q;
  logic ms_tick, proc_tick;
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q, wr_do;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, wr_val, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic run_q, restart_q;
  logic [1:0] alias_src_q, xid_src_q;
  logic alias_fmt_q, xid_fmt_q;
  logic [15:0] alias_store_q, xid_store_q, alias_q, xid_q;
  logic [NCONS-1:0][1:0] cfg_def_q, act_def_q;
  logic [NCONS-1:0][7:0] cfg_pvt_q, act_pvt_q;
  logic [NCONS-1:0][8:0] tmr_q;
  logic [NCONS-1:0][NAREA-1:0][23:0] cfg_area_q, act_area_q;
  logic [NCONS-1:0] map_err_q, stale_q, expired, fresh;
  logic [3:0] irq_stat_q, irq_en_q, irq_ev;
  logic [15:0] in_mem_q [IN_WORDS];
  logic [15:0] out_mem_q [NCONS][OUT_WORDS];
  logic [15:0] cons_data_q;
  obm_eng_t eng_q;
  logic [1:0] ec_q, ea_q;
  logic [7:0] ek_q, cur_n;
  logic [4:0] ed_q;
  logic [23:0] cur;
  logic eng_wr, def_wr;
  logic [15:0] eng_word;
  logic [15:0] sw_s1_q, sw_s2_q, sw_s3_q, sw_q;

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic map_ok(input logic [NAREA-1:0][23:0] ar);
    logic [16:0] tot;
    logic [16:0] end_w;
    logic ok;
    tot = 17'h0;
    ok = 1'b1;
    for (int a = 0; a < NAREA; a++) begin
      end_w = 17'(ar[a][15:0]) - 17'(IN_BASE) + 17'(ar[a][23:16]);
      if (ar[a][23:16] != 8'h00 &&
          (ar[a][15:0] < IN_BASE || end_w > 17'(IN_WORDS))) begin
        ok = 1'b0;
      end
      tot = tot + 17'(ar[a][23:16]);
    end
    if (tot > 17'(OUT_WORDS)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  function automatic logic area_hit(input logic [NAREA-1:0][23:0] ar,
                                    input logic [15:0] ad);
    logic hit;
    hit = 1'b0;
    for (int a = 0; a < NAREA; a++) begin
      if (ad >= ar[a][15:0] &&
          17'(ad) < 17'(ar[a][15:0]) + 17'(ar[a][23:16])) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [1:0] cons_of(input logic [7:0] ad);
    return 2'((ad - A_CONS) >> CONS_SHIFT);
  endfunction

  function automatic logic addr_ok(input logic [7:0] ad);
    return (ad[1:0] == 2'h0) &&
           ((ad <= A_XID_VAL) ||
            (ad >= A_CONS && ad < A_CONS_END && ad[4:2] <= R_AREA3));
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] ad);
    logic [31:0] r;
    logic [1:0] c;
    r = 32'h0;
    c = cons_of(ad);
    unique case (ad)
      A_CTRL: r[CTRL_RUN] = run_q;
      A_STATUS: begin
        r[NCONS-1:0] = map_err_q;
        r[ST_RUN] = run_q;
        r[ST_STALE +: NCONS] = stale_q;
      end
      A_IRQ_STAT: r[3:0] = irq_stat_q;
      A_IRQ_EN: r[3:0] = irq_en_q;
      A_ALIAS_CFG: r[2:0] = {alias_fmt_q, alias_src_q};
      A_ALIAS_STORE: r[15:0] = alias_store_q;
      A_ALIAS_VAL: r[15:0] = alias_q;
      A_XID_CFG: r[2:0] = {xid_fmt_q, xid_src_q};
      A_XID_STORE: r[15:0] = xid_store_q;
      A_XID_VAL: r[15:0] = xid_q;
      default: begin
        if (ad >= A_CONS && ad < A_CONS_END) begin
          if (ad[4:2] == R_DEF) begin
            r[1:0] = cfg_def_q[c];
          end else if (ad[4:2] == R_PVT) begin
            r[7:0] = cfg_pvt_q[c];
          end else if (ad[4:2] <= R_AREA3) begin
            r[23:0] = cfg_area_q[c][2'(ad[4:2] - R_AREA0)];
          end
        end
      end
    endcase
    return r;
  endfunction

  // ******************************************************************
  // reset release and enable dividers
  // ******************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff_q <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_ff_q <= 1'b1;
      rst_sync_n_q <= rst_ff_q;
    end
  end

  obm_tick #(.PERIOD(MS_CYCLES)) u_ms_tick (
    .clock(clock),
    .rst_n(rst_sync_n_q),
    .tick(ms_tick)
  );

  obm_tick #(.PERIOD(PROC_CYCLES)) u_proc_tick (
    .clock(clock),
    .rst_n(rst_sync_n_q),
    .tick(proc_tick)
  );

  // ******************************************************************
  // axi4-lite slave
  // ******************************************************************
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_do = aw_full_q && w_full_q && !bvalid_q;

  always_comb begin
    wr_val = rd_word(aw_addr_q);
    for (int b = 0; b < 4; b++) begin
      if (w_strb_q[b]) begin
        wr_val[8*b +: 8] = w_data_q[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_do) begin
        w_full_q <= 1'b0;
      end
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q <= addr_ok(aw_addr_q) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= AXI_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word(s_axi_araddr);
      rresp_q <= addr_ok(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ******************************************************************
  // control, restart and identifier settings
  // ******************************************************************
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      run_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_do && aw_addr_q == A_CTRL && wr_val[CTRL_RESTART];
      if (wr_do && aw_addr_q == A_CTRL) begin
        run_q <= wr_val[CTRL_RUN];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      alias_src_q <= SRC_STORE;
      alias_fmt_q <= 1'b0;
      alias_store_q <= 16'h0000;
      xid_src_q <= SRC_STORE;
      xid_fmt_q <= 1'b0;
      xid_store_q <= 16'h0000;
    end else if (wr_do) begin
      unique case (aw_addr_q)
        A_ALIAS_CFG: begin
          alias_src_q <= wr_val[1:0];
          alias_fmt_q <= wr_val[CFG_FMT];
        end
        A_ALIAS_STORE: alias_store_q <= wr_val[15:0];
        A_XID_CFG: begin
          xid_src_q <= wr_val[1:0];
          xid_fmt_q <= wr_val[CFG_FMT];
        end
        A_XID_STORE: xid_store_q <= wr_val[15:0];
        default: ;
      endcase
    end
  end

  // ******************************************************************
  // per-consumer configuration, staged until restart
  // ******************************************************************
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      cfg_def_q <= {NCONS{DEF_KEEP}};
      cfg_pvt_q <= '0;
      cfg_area_q <= '0;
    end else if (wr_do && aw_addr_q >= A_CONS && aw_addr_q < A_CONS_END) begin
      if (aw_addr_q[4:2] == R_DEF) begin
        cfg_def_q[cons_of(aw_addr_q)] <= wr_val[1:0];
      end else if (aw_addr_q[4:2] == R_PVT) begin
        cfg_pvt_q[cons_of(aw_addr_q)] <= wr_val[7:0];
      end else if (aw_addr_q[4:2] <= R_AREA3) begin
        cfg_area_q[cons_of(aw_addr_q)][2'(aw_addr_q[4:2] - R_AREA0)] <=
          wr_val[23:0];
      end
    end
  end

  // the running copy only ever changes on restart, so an edit half
  // way through a copy pass cannot tear the output data
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      act_def_q <= {NCONS{DEF_KEEP}};
      act_pvt_q <= '0;
      act_area_q <= '0;
      map_err_q <= '0;
    end else if (restart_q) begin
      act_def_q <= cfg_def_q;
      act_pvt_q <= cfg_pvt_q;
      act_area_q <= cfg_area_q;
      for (int c = 0; c < NCONS; c++) begin
        map_err_q[c] <= !map_ok(cfg_area_q[c]);
      end
    end
  end

  // ******************************************************************
  // input data area and validity timers
  // ******************************************************************
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      for (int i = 0; i < IN_WORDS; i++) begin
        in_mem_q[i] <= 16'h0000;
      end
    end else if (prod_we && prod_addr >= IN_BASE &&
                 17'(prod_addr) < 17'(IN_BASE) + 17'(IN_WORDS)) begin
      in_mem_q[4'(prod_addr - IN_BASE)] <= prod_data;
    end
  end

  always_comb begin
    for (int c = 0; c < NCONS; c++) begin
      fresh[c] = prod_we && !map_err_q[c] &&
                 area_hit(act_area_q[c], prod_addr);
      expired[c] = act_pvt_q[c] != 8'h00 &&
                   tmr_q[c] > 9'(act_pvt_q[c]);
    end
  end

  // timer counts whole ms ticks and parks past the period
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      tmr_q <= '0;
      stale_q <= '0;
    end else begin
      stale_q <= expired;
      for (int c = 0; c < NCONS; c++) begin
        if (restart_q || fresh[c]) begin
          tmr_q[c] <= 9'h000;
        end else if (ms_tick && run_q && !expired[c]) begin
          tmr_q[c] <= tmr_q[c] + 9'h001;
        end
      end
    end
  end

  // ******************************************************************
  // copy engine: one word per clock, consumer then area order
  // ******************************************************************
  assign cur = act_area_q[ec_q][ea_q];
  assign cur_n = map_err_q[ec_q] ? 8'h00 : cur[23:16];
  assign eng_wr = eng_q == ENG_COPY && ek_q < cur_n;
  assign def_wr = act_def_q[ec_q] == DEF_ZERO ||
                  act_def_q[ec_q] == DEF_ONE;

  always_comb begin
    if (!expired[ec_q]) begin
      eng_word = in_mem_q[4'(cur[15:0] - IN_BASE + 16'(ek_q))];
    end else if (act_def_q[ec_q] == DEF_ONE) begin
      eng_word = 16'hFFFF;
    end else begin
      eng_word = 16'h0000;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      eng_q <= ENG_IDLE;
      ec_q <= 2'h0;
      ea_q <= 2'h0;
      ek_q <= 8'h00;
      ed_q <= 5'h00;
    end else if (restart_q) begin
      eng_q <= ENG_IDLE;
    end else begin
      unique case (eng_q)
        ENG_IDLE: begin
          if (proc_tick && run_q) begin
            eng_q <= ENG_COPY;
            ec_q <= 2'h0;
            ea_q <= 2'h0;
            ek_q <= 8'h00;
            ed_q <= 5'h00;
          end
        end
        ENG_COPY: begin
          if (eng_wr) begin
            ek_q <= ek_q + 8'h01;
            ed_q <= ed_q + 5'h01;
          end else begin
            ek_q <= 8'h00;
            if (ea_q == 2'(NAREA - 1)) begin
              ea_q <= 2'h0;
              ed_q <= 5'h00;
              if (ec_q == 2'(NCONS - 1)) begin
                eng_q <= ENG_IDLE;
              end else begin
                ec_q <= ec_q + 2'h1;
              end
            end else begin
              ea_q <= ea_q + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // keep mode simply skips the write, leaving the last good values
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      for (int c = 0; c < NCONS; c++) begin
        for (int i = 0; i < OUT_WORDS; i++) begin
          out_mem_q[c][i] <= 16'h0000;
        end
      end
    end else if (eng_wr && (!expired[ec_q] || def_wr)) begin
      out_mem_q[ec_q][ed_q[3:0]] <= eng_word;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      cons_data_q <= 16'h0000;
    end else if (cons_sel < 2'(NCONS)) begin
      cons_data_q <= out_mem_q[cons_sel][cons_idx];
    end else begin
      cons_data_q <= 16'h0000;
    end
  end

  assign cons_data = cons_data_q;
  assign cons_stale = stale_q;

  // ******************************************************************
  // interrupts: set wins over a clear in the same cycle
  // ******************************************************************
  assign irq_ev = {restart_q && !map_ok(cfg_area_q[0]) ||
                   restart_q && !map_ok(cfg_area_q[1]) ||
                   restart_q && !map_ok(cfg_area_q[2]),
                   expired & ~stale_q};

  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      irq_stat_q <= 4'h0;
      irq_en_q <= 4'h0;
    end else begin
      if (wr_do && aw_addr_q == A_IRQ_CLR) begin
        irq_stat_q <= (irq_stat_q & ~wr_val[3:0]) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      if (wr_do && aw_addr_q == A_IRQ_EN) begin
        irq_en_q <= wr_val[3:0];
      end
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // ******************************************************************
  // switch chain word, alias and device id
  // ******************************************************************
  // pins settle through three stages; a change counts once two agree
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      sw_s1_q <= 16'h0000;
      sw_s2_q <= 16'h0000;
      sw_s3_q <= 16'h0000;
      sw_q <= 16'h0000;
    end else begin
      sw_s1_q <= sw_pins;
      sw_s2_q <= sw_s1_q;
      sw_s3_q <= sw_s2_q;
      if (sw_s2_q == sw_s3_q) begin
        sw_q <= sw_s3_q;
      end
    end
  end

  obm_sw_if alias_if ();
  obm_sw_if xid_if ();
  assign alias_if.raw = sw_q;
  assign alias_if.bcd = !alias_fmt_q;
  assign xid_if.raw = sw_q;
  assign xid_if.bcd = !xid_fmt_q;

  obm_sw_dec u_alias_dec (
    .clock(clock),
    .rst_n(rst_sync_n_q),
    .sw(alias_if.dec)
  );

  obm_sw_dec u_xid_dec (
    .clock(clock),
    .rst_n(rst_sync_n_q),
    .sw(xid_if.dec)
  );

  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      alias_q <= 16'h0000;
      xid_q <= 16'h0000;
    end else begin
      unique case (alias_src_q)
        SRC_STORE: alias_q <= alias_store_q;
        SRC_SWITCH: alias_q <= alias_if.value;
        SRC_MASTER: alias_q <= master_alias;
        default: ;
      endcase
      unique case (xid_src_q)
        SRC_STORE: xid_q <= xid_store_q;
        SRC_SWITCH: xid_q <= xid_if.value;
        default: ;
      endcase
    end
  end

  assign station_alias = alias_q;
  assign device_id = xid_q;

endmodule

/* pkg/obm_pkg.sv */
// shared constants and types of the output mapping broker
//
// Contract
// - four source areas copied per consumer
// - each consumer has own map, default, timeout
// - out-of-range area or count flagged, rejected
// - new mapping applies after restart, in run
// - default codes: zeros, ones, keep old
// - validity period 0..255 ms per consumer
// - period zero disables the timeout
// - stale producer data replaced by default
// - alias from store, switches or master
// - alias store holds 0..65535
// - switch word decoded bcd or binary
// - device id from store or switches
// - device id store holds 0..65535
package obm_pkg;

  // ******************************************************************
  // sizes
  // ******************************************************************
  localparam int NCONS = 3;
  localparam int NAREA = 4;
  localparam int IN_WORDS = 16;
  localparam int OUT_WORDS = 16;
  localparam logic [15:0] IN_BASE = 16'h1000;

  // ******************************************************************
  // timing
  // ******************************************************************
  localparam int CLK_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam int PROC_NS = 100000;
  localparam int PROC_CYC = PROC_NS / CLK_NS;

  // ******************************************************************
  // register byte addresses and fields
  // ******************************************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_IRQ_STAT = 8'h08;
  localparam logic [7:0] A_IRQ_CLR = 8'h0C;
  localparam logic [7:0] A_IRQ_EN = 8'h10;
  localparam logic [7:0] A_ALIAS_CFG = 8'h14;
  localparam logic [7:0] A_ALIAS_STORE = 8'h18;
  localparam logic [7:0] A_ALIAS_VAL = 8'h1C;
  localparam logic [7:0] A_XID_CFG = 8'h20;
  localparam logic [7:0] A_XID_STORE = 8'h24;
  localparam logic [7:0] A_XID_VAL = 8'h28;
  localparam logic [7:0] A_CONS = 8'h40;
  localparam logic [7:0] A_CONS_END = 8'hA0;
  localparam int CONS_SHIFT = 5;
  localparam logic [2:0] R_DEF = 3'h0;
  localparam logic [2:0] R_PVT = 3'h1;
  localparam logic [2:0] R_AREA0 = 3'h2;
  localparam logic [2:0] R_AREA3 = 3'h5;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CFG_FMT = 2;
  localparam int ST_RUN = 3;
  localparam int ST_STALE = 4;
  localparam int IRQ_MAPERR = 3;

  // ******************************************************************
  // codes and reset values
  // ******************************************************************
  localparam logic [1:0] DEF_ZERO = 2'h1;
  localparam logic [1:0] DEF_ONE = 2'h2;
  localparam logic [1:0] DEF_KEEP = 2'h3;
  localparam logic [1:0] SRC_STORE = 2'h1;
  localparam logic [1:0] SRC_SWITCH = 2'h2;
  localparam logic [1:0] SRC_MASTER = 2'h3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] BCD_DIG_W = 8'h0A;
  localparam logic [15:0] BCD_HI_W = 16'h0064;

  typedef enum logic {ENG_IDLE, ENG_COPY} obm_eng_t;

endpackage

/* pkg/obm_sw_if.sv */
// switch word carrier between the top and its decoders
interface obm_sw_if;
  logic [15:0] raw;
  logic bcd;
  logic [15:0] value;
  modport dec (input raw, input bcd, output value);
  modport user (output raw, output bcd, input value);
endinterface

/* hw/obm_tick.sv */
// free running divider giving a one-cycle enable pulse
module obm_tick #(
  parameter int PERIOD = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // enable pulse
  output logic tick
);
  logic [31:0] cnt_q;
  logic tick_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (cnt_q == 32'(PERIOD - 1)) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;
endmodule

/* hw/obm_sw_dec.sv */
// switch word decoder, bcd or binary, keeps last good value
module obm_sw_dec
  import obm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // switch word and decoded value
  obm_sw_if.dec sw
);
  logic [15:0] val_q;
  logic bad;

  function automatic logic [7:0] bcd_byte(input logic [7:0] b);
    return 8'(b[7:4] * BCD_DIG_W) + 8'(b[3:0]);
  endfunction

  assign bad = (sw.raw[15:12] > BCD_MAX) || (sw.raw[11:8] > BCD_MAX) ||
               (sw.raw[7:4] > BCD_MAX) || (sw.raw[3:0] > BCD_MAX);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      val_q <= 16'h0000;
    end else if (!sw.bcd) begin
      val_q <= sw.raw;
    end else if (!bad) begin
      val_q <= 16'(bcd_byte(sw.raw[15:8]) * BCD_HI_W) +
               16'(bcd_byte(sw.raw[7:0]));
    end
  end

  assign sw.value = val_q;
endmodule

/* testbench/obm_monitor.sv */
// port checks of the output mapping broker
module obm_monitor (
  // clock and reset
  input wire logic clock, rst_n,
  // register bus
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // consumer read port
  input wire logic [1:0] cons_sel,
  input wire logic [15:0] cons_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_blat; s_wr |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
  a_blat: assert property (p_blat) else $error("late bvalid");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write not closed");
  property p_awbusy; s_wr |=> !s_axi_awready && !s_axi_wready;
  endproperty
  a_awbusy: assert property (p_awbusy) else $error("write ready early");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("late rvalid");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rdata changed");
  property p_rdone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read not closed");
  property p_sel3; cons_sel == 2'h3 |=> cons_data == 16'h0000; endproperty
  a_sel3: assert property (p_sel3) else $error("spare consumer data");
endmodule
bind obm_top obm_monitor mon_u (.*);

/* testbench/obm_partner.sv */
// producer and identifier sources at the broker's far side
module obm_partner
  import obm_pkg::*;
(
  // bench control
  input wire logic clock,
  input wire logic en,
  input wire logic [15:0] sw_val,
  // producer and identifier sources
  output logic prod_we,
  output logic [15:0] prod_addr,
  output logic [15:0] prod_data,
  output logic [15:0] sw_pins,
  output logic [15:0] master_alias
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] k_q = 4'h0;
  initial {prod_we, prod_addr, prod_data} = '0;
  assign sw_pins = sw_val;
  // arbitrary value
  assign master_alias = 16'h5A3C;
  // idle lines invert so a stale value never looks valid
  always @(posedge clock) begin
    k_q <= k_q + 4'h1;
    prod_we <= en;
    prod_addr <= en ? IN_BASE + {12'h0, k_q} : ~prod_addr;
    prod_data <= en ? {12'hA50, k_q} : ~prod_data;
  end
endmodule

/* testbench/tb_top.sv */
// self-checking bench of the output mapping broker
module tb_top;
  import obm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_n = 1'b0, en = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF, cons_idx = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, prod_we;
  logic [1:0] cons_sel = 2'h0, s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] sw_val = 16'h0, sw_pins, prod_addr, prod_data;
  logic [15:0] master_alias, station_alias, device_id, cons_data;
  logic [2:0] cons_stale;
  int err_count = 0, check_count = 0, cyc = 0;
  always #2.5 clock = ~clock;
  obm_top #(.MS_CYCLES(20), .PROC_CYCLES(200)) dut_u (.*);
  obm_partner pm_u (.*);
  task wrap_up;
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {d, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task cr(input int c, input logic [3:0] i, input logic [15:0] e);
    @(posedge clock);
    cons_sel <= 2'(c);
    cons_idx <= i;
    tk(2);
    #1 chk(cons_data, e);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up;
    end
  end
  initial begin
    tk(10);
    rst_n <= 1'b1;
    tk(3);
    wr(A_ALIAS_STORE, 32'hFFFF);
    wr(A_XID_STORE, 32'hFFFF);
    tk(4);
    chk(station_alias, 16'hFFFF);
    chk(device_id, 16'hFFFF);
    rd(A_ALIAS_VAL);
    chk(d[15:0], 16'hFFFF);
    rd(8'hFC);
    chk({14'h0, rs}, {14'h0, AXI_SLVERR});
    wr(8'hFC, 32'h0);
    chk(16'(rs), 16'(AXI_SLVERR));
    sw_val <= 16'h1234;
    wr(A_ALIAS_CFG, 32'h2);
    tk(10);
    chk(station_alias, 16'h04D2);
    sw_val <= 16'h12A4;
    tk(10);
    chk(station_alias, 16'h04D2);
    wr(A_ALIAS_CFG, 32'h6);
    wr(A_XID_CFG, 32'h6);
    tk(10);
    chk(station_alias, 16'h12A4);
    chk(device_id, 16'h12A4);
    wr(A_ALIAS_CFG, 32'h3);
    tk(4);
    chk(station_alias, 16'h5A3C);
    en <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      wr(A_CONS + 8'(c << CONS_SHIFT), 32'(c + 1));
      wr(A_CONS + 8'(c << CONS_SHIFT) + 8'h4, 32'(c < 2));
      wr(A_CONS + 8'(c << CONS_SHIFT) + 8'h8, 32'h0002_1002);
    end
    wr(A_CTRL, 32'h3);
    tk(450);
    for (int c = 0; c < 3; c++) begin
      cr(c, 4'h0, 16'hA502);
      cr(c, 4'h1, 16'hA503);
    end
    cr(3, 4'h0, 16'h0000);
    en <= 1'b0;
    tk(500);
    cr(0, 4'h0, 16'h0000);
    cr(1, 4'h0, 16'hFFFF);
    cr(2, 4'h0, 16'hA502);
    chk({13'h0, cons_stale}, 16'h3);
    wr(A_IRQ_EN, 32'h8);
    wr(A_CONS + 8'h2C, 32'h0002_100F);
    rd(A_STATUS);
    chk({13'h0, d[2:0]}, 16'h0);
    wr(A_CTRL, 32'h3);
    tk(3);
    rd(A_STATUS);
    chk({13'h0, d[2:0]}, 16'h2);
    chk({15'h0, irq}, 16'h1);
    wr(A_IRQ_CLR, 32'h8);
    tk(2);
    chk({15'h0, irq}, 16'h0);
    wrap_up;
  end
endmodule
